// *** verilog/eic_regs.vh ***
`ifndef EIC_REGS_VH
`define EIC_REGS_VH
// special function register addresses
`define EIC_ADDR_PIN_CFG 8'he4
`define EIC_ADDR_PRIO_TWO 8'hf7
`define EIC_ADDR_ENABLE_TWO 8'he7
`define EIC_ADDR_TIMER_CTRL 8'h88
// reset values
`define EIC_RST_PIN_CFG 8'h01
`define EIC_RST_PRIO_TWO 8'h00
`define EIC_RST_ENABLE_TWO 8'h00
`define EIC_RST_TRIG_TYPE 2'h0
`define EIC_RST_PEND 1'h0
`define EIC_RST_PREV 1'h1
`define EIC_RST_SYNC 1'h0
`define EIC_RST_RDATA 8'h00
// pin configuration fields
`define EIC_EXT1_POL_BIT 7
`define EIC_EXT1_SEL_HI 6
`define EIC_EXT1_SEL_LO 4
`define EIC_EXT0_POL_BIT 3
`define EIC_EXT0_SEL_HI 2
`define EIC_EXT0_SEL_LO 0
// priority two fields
`define EIC_PORT_MATCH_PRIORITY_PRIO_BIT 3
`define EIC_RSVD_PRIO_BIT 2
`define EIC_UART1_PRIO_BIT 1
`define EIC_VBUS_PRIO_BIT 0
`define EIC_PRIO_TWO_MASK 8'h0f
// enable two fields
`define EIC_PORT_MATCH_PRIORITY_EN_BIT 3
`define EIC_UART1_EN_BIT 1
`define EIC_VBUS_EN_BIT 0
`define EIC_ENABLE_TWO_MASK 8'h0f
// timer control fields
`define EIC_EXT1_PEND_BIT 3
`define EIC_EXT1_TRIG_BIT 2
`define EIC_EXT0_PEND_BIT 1
`define EIC_EXT0_TRIG_BIT 0
`endif

// *** verilog/eic_core.v ***
// Notes on behaviour
// - port match interrupt is high priority when its priority bit (bit 3) is one.
// - second uart interrupt is high priority when its priority bit (bit 1) is one.
// - bus voltage interrupt is high priority when its priority bit (bit 0) is one.
// - the upper four bits of priority register two read zero and ignore writes.
// - a trigger type bit of one makes its input edge sensitive, zero level sensitive.
// - a polarity bit of one makes its input active high, zero active low.
// - each pin select field picks port-0 pin n for its input, zero picking pin 0.
// - the selected pin is only observed, never driven, so its peripheral is undisturbed.
// - a set skip mask bit keeps the crossbar from giving that pin to a peripheral.
// - input 0 pending sits in timer control bit 1, input 1 pending in bit 3.
// - in edge mode pending sets on an active edge and clears when the cpu vectors to it.
// - in level mode pending simply follows the active state of the input.
// - port match, uart and bus voltage requests pass only while enabled.
`timescale 1ns/1ps
`include "eic_regs.vh"
module eic_core (
  input wire sys_clk, // system clock, 20 MHz
  input wire rst_n, // asynchronous reset, active low
  input wire clk_en, // freezes all state while low
  input wire [7:0] port0_pin, // port-0 pin levels, asynchronous
  input wire [7:0] periph_pin_req, // crossbar pin claims by peripherals
  input wire [7:0] crossbar_skip_mask, // pins withheld from the crossbar
  input wire [7:0] sfr_addr, // register address
  input wire [7:0] sfr_wdata, // register write data
  input wire sfr_wr, // register write strobe
  input wire sfr_rd, // register read strobe
  input wire [1:0] ext_vector_ack, // cpu vectors to ext0/ext1 routine
  input wire port_match_req, // port match interrupt source
  input wire uart1_req, // second uart interrupt source
  input wire vbus_req, // bus voltage interrupt source
  output reg [7:0] sfr_rdata, // register read data
  output wire [7:0] crossbar_grant, // pins the crossbar may assign
  output wire ext_irq_zero, // input 0 pending request
  output wire ext_irq_one, // input 1 pending request
  output wire port_match_irq, // gated port match request
  output wire uart1_irq, // gated second uart request
  output wire vbus_irq, // gated bus voltage request
  output wire port_match_priority, // port match high priority
  output wire uart1_priority, // second uart high priority
  output wire vbus_priority // bus voltage high priority
);
  reg [7:0] ext_irq_pin_polarity_cfg;
  reg [7:0] extended_priority_two;
  reg [7:0] extended_enable_two;
  reg [1:0] trigger_type;
  reg [7:0] next_pin_cfg;
  reg [7:0] next_prio_two;
  reg [7:0] next_enable_two;
  reg [1:0] next_trigger_type;
  reg [7:0] next_rdata;
  reg wr_cfg;
  reg wr_prio;
  reg wr_en;
  reg wr_timer_control_reg;
  wire [7:0] pin_sync;
  wire [1:0] pending;
  wire [1:0] active;
  wire [2:0] sel0;
  wire [2:0] sel1;
  wire [1:0] pol;
  wire [1:0] pend_wval;
  wire rd_any;
  wire [2:0] src_req;
  wire [2:0] src_en_bit;
  wire [2:0] src_irq;

  // one write strobe per held register; unmapped addresses write nothing
  always @* begin
    wr_cfg = 1'h0;
    wr_prio = 1'h0;
    wr_en = 1'h0;
    wr_timer_control_reg = 1'h0;
    if (clk_en && sfr_wr) begin
      case (sfr_addr)
        `EIC_ADDR_PIN_CFG: begin
          wr_cfg = 1'h1;
        end
        `EIC_ADDR_PRIO_TWO: begin
          wr_prio = 1'h1;
        end
        `EIC_ADDR_ENABLE_TWO: begin
          wr_en = 1'h1;
        end
        `EIC_ADDR_TIMER_CTRL: begin
          wr_timer_control_reg = 1'h1;
        end
        default: begin
          wr_cfg = 1'h0;
        end
      endcase
    end
  end

  assign rd_any = clk_en && sfr_rd;

  // pins are only sampled, never driven
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_pin_sync
      reg meta_q;
      reg sync_q;
      // only sync_q is read outside this pair, meta_q may be metastable
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= `EIC_RST_SYNC;
          sync_q <= `EIC_RST_SYNC;
        end else if (clk_en) begin
          meta_q <= port0_pin[b];
          sync_q <= meta_q;
        end
      end
      assign pin_sync[b] = sync_q;
    end
  endgenerate

  assign crossbar_grant = periph_pin_req & ~crossbar_skip_mask;

  // select and polarity act at once; changing them can itself look like an edge
  assign sel0 = ext_irq_pin_polarity_cfg[`EIC_EXT0_SEL_HI:`EIC_EXT0_SEL_LO];
  assign sel1 = ext_irq_pin_polarity_cfg[`EIC_EXT1_SEL_HI:`EIC_EXT1_SEL_LO];
  assign pol = {ext_irq_pin_polarity_cfg[`EIC_EXT1_POL_BIT],
                ext_irq_pin_polarity_cfg[`EIC_EXT0_POL_BIT]};
  assign pend_wval = {sfr_wdata[`EIC_EXT1_PEND_BIT],
                      sfr_wdata[`EIC_EXT0_PEND_BIT]};

  always @* begin
    next_pin_cfg = ext_irq_pin_polarity_cfg;
    next_prio_two = extended_priority_two;
    next_enable_two = extended_enable_two;
    next_trigger_type = trigger_type;
    if (wr_cfg) begin
      next_pin_cfg = sfr_wdata;
    end
    if (wr_prio) begin
      // unused upper bits are never stored, so they read back as zero
      next_prio_two = sfr_wdata & `EIC_PRIO_TWO_MASK;
    end
    if (wr_en) begin
      next_enable_two = sfr_wdata & `EIC_ENABLE_TWO_MASK;
    end
    if (wr_timer_control_reg) begin
      next_trigger_type[1] = sfr_wdata[`EIC_EXT1_TRIG_BIT];
      next_trigger_type[0] = sfr_wdata[`EIC_EXT0_TRIG_BIT];
    end
  end

  // clk_en low freezes every register, the pin synchronisers included
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_pin_polarity_cfg <= `EIC_RST_PIN_CFG;
      extended_priority_two <= `EIC_RST_PRIO_TWO;
      extended_enable_two <= `EIC_RST_ENABLE_TWO;
      trigger_type <= `EIC_RST_TRIG_TYPE;
    end else if (clk_en) begin
      ext_irq_pin_polarity_cfg <= next_pin_cfg;
      extended_priority_two <= next_prio_two;
      extended_enable_two <= next_enable_two;
      trigger_type <= next_trigger_type;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ext
      wire [2:0] sel;
      wire trig;
      wire edge_seen;
      wire set_evt;
      wire clr_evt;
      wire sw_load;
      reg sel_pin;
      reg prev_q;
      reg pend_q;
      reg next_pend;

      assign sel = (i == 0) ? sel0 : sel1;
      assign trig = trigger_type[i];
      // one select code per pin, so every port-0 pin is reachable
      always @* begin
        sel_pin = 1'h0;
        case (sel)
          3'h0: begin
            sel_pin = pin_sync[0];
          end
          3'h1: begin
            sel_pin = pin_sync[1];
          end
          3'h2: begin
            sel_pin = pin_sync[2];
          end
          3'h3: begin
            sel_pin = pin_sync[3];
          end
          3'h4: begin
            sel_pin = pin_sync[4];
          end
          3'h5: begin
            sel_pin = pin_sync[5];
          end
          3'h6: begin
            sel_pin = pin_sync[6];
          end
          3'h7: begin
            sel_pin = pin_sync[7];
          end
          default: begin
            sel_pin = 1'h0;
          end
        endcase
      end

      assign active[i] = ~(sel_pin ^ pol[i]);
      assign edge_seen = active[i] && !prev_q;
      assign set_evt = trig && edge_seen;
      assign clr_evt = trig && ext_vector_ack[i];
      assign sw_load = trig && wr_timer_control_reg;
      always @* begin
        next_pend = pend_q;
        if (!trig) begin
          // no latching; a level still active after return requests again
          next_pend = active[i];
        end else if (set_evt) begin
          // a new edge wins over the vector clear or a software write
          next_pend = 1'h1;
        end else if (clr_evt) begin
          next_pend = 1'h0;
        end else if (sw_load) begin
          next_pend = pend_wval[i];
        end
      end
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          // matches a low pin under the reset polarity, so no false edge follows reset
          prev_q <= `EIC_RST_PREV;
          pend_q <= `EIC_RST_PEND;
        end else if (clk_en) begin
          prev_q <= active[i];
          pend_q <= next_pend;
        end
      end
      assign pending[i] = pend_q;
    end
  endgenerate

  assign ext_irq_zero = pending[0];
  assign ext_irq_one = pending[1];

  assign port_match_priority = extended_priority_two[`EIC_PORT_MATCH_PRIORITY_PRIO_BIT];
  assign uart1_priority = extended_priority_two[`EIC_UART1_PRIO_BIT];
  assign vbus_priority = extended_priority_two[`EIC_VBUS_PRIO_BIT];

  // the three cpu-side sources share one gate shape
  assign src_req = {port_match_req, uart1_req, vbus_req};
  assign src_en_bit = {extended_enable_two[`EIC_PORT_MATCH_PRIORITY_EN_BIT],
                       extended_enable_two[`EIC_UART1_EN_BIT],
                       extended_enable_two[`EIC_VBUS_EN_BIT]};
  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : g_src
      assign src_irq[s] = src_req[s] && src_en_bit[s];
    end
  endgenerate
  assign port_match_irq = src_irq[2];
  assign uart1_irq = src_irq[1];
  assign vbus_irq = src_irq[0];

  always @* begin
    next_rdata = 8'h00;
    case (sfr_addr)
      `EIC_ADDR_PIN_CFG: begin
        next_rdata = ext_irq_pin_polarity_cfg;
      end
      `EIC_ADDR_PRIO_TWO: begin
        next_rdata = extended_priority_two;
      end
      `EIC_ADDR_ENABLE_TWO: begin
        next_rdata = extended_enable_two;
      end
      `EIC_ADDR_TIMER_CTRL: begin
        next_rdata[`EIC_EXT1_PEND_BIT] = pending[1];
        next_rdata[`EIC_EXT1_TRIG_BIT] = trigger_type[1];
        next_rdata[`EIC_EXT0_PEND_BIT] = pending[0];
        next_rdata[`EIC_EXT0_TRIG_BIT] = trigger_type[0];
      end
      default: begin
        // unmapped addresses read as zero
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stands until the next read strobe
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= `EIC_RST_RDATA;
    end else if (rd_any) begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule

// *** tb/eic_asserts.sv ***
`timescale 1ns/1ps
module eic_asserts (
  input wire sys_clk, // clock
  input wire rst_n, // reset
  input wire clk_en, // run
  input wire [7:0] periph_pin_req, // claims
  input wire [7:0] crossbar_skip_mask, // skip
  input wire [7:0] sfr_addr, // addr
  input wire [7:0] sfr_wdata, // wdata
  input wire sfr_wr, // wr
  input wire sfr_rd, // rd
  input wire port_match_req, // src
  input wire uart1_req, // src
  input wire vbus_req, // src
  input wire [7:0] sfr_rdata, // rdata
  input wire [7:0] crossbar_grant, // grant
  input wire port_match_irq, // irq
  input wire uart1_irq, // irq
  input wire vbus_irq, // irq
  input wire port_match_priority, // prio
  input wire uart1_priority, // prio
  input wire vbus_priority // prio
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire pw = sfr_wr && clk_en && sfr_addr == 8'hf7;
  wire pr = sfr_rd && clk_en && sfr_addr == 8'hf7;
  reg [7:0] en_seen;
  // shadow of the enable register, built from the bus alone
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) en_seen <= 8'h00;
    else if (sfr_wr && clk_en && sfr_addr == 8'he7) en_seen <= sfr_wdata;
  end
  a_grant_skip: assert property (crossbar_grant == (periph_pin_req & ~crossbar_skip_mask))
    else $error("grant not masked");
  a_port_match_priority_gate: assert property (port_match_irq == (port_match_req && en_seen[3]))
    else $error("port match irq gate wrong");
  a_uart_gate: assert property (uart1_irq == (uart1_req && en_seen[1]))
    else $error("uart irq gate wrong");
  a_vbus_gate: assert property (vbus_irq == (vbus_req && en_seen[0]))
    else $error("vbus irq gate wrong");
  a_port_match_priority_prio: assert property (pw |=> port_match_priority == $past(sfr_wdata[3]))
    else $error("port match priority wrong");
  a_uart_prio: assert property (pw |=> uart1_priority == $past(sfr_wdata[1]))
    else $error("uart priority wrong");
  a_vbus_prio: assert property (pw |=> vbus_priority == $past(sfr_wdata[0]))
    else $error("vbus priority wrong");
  a_prio_upper: assert property (pr |=> sfr_rdata[7:4] == 4'h0)
    else $error("priority upper bits nonzero");
  cover property (pw);
  cover property (pr);
  cover property (port_match_irq && uart1_irq);
endmodule
bind eic_core eic_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .periph_pin_req(periph_pin_req), .crossbar_skip_mask(crossbar_skip_mask),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .port_match_req(port_match_req), .uart1_req(uart1_req), .vbus_req(vbus_req),
  .sfr_rdata(sfr_rdata), .crossbar_grant(crossbar_grant), .port_match_irq(port_match_irq),
  .uart1_irq(uart1_irq), .vbus_irq(vbus_irq), .port_match_priority(port_match_priority),
  .uart1_priority(uart1_priority), .vbus_priority(vbus_priority));

// *** tb/eic_src_model.sv ***
`timescale 1ns/1ps
module eic_src_model (
  input wire sys_clk, // clock
  input wire [7:0] level, // requested pin levels
  output reg [7:0] port0_pin // driven pin levels
);
  initial port0_pin = 8'h00;
  // levels are held until told otherwise, so a request stays up until level drops, serviced or not
  always @(posedge sys_clk) port0_pin <= #5 level;
endmodule

// *** tb/external_interrupt_config_tb.sv ***
`timescale 1ns/1ps
module external_interrupt_config_tb;
  logic sys_clk = 0, rst_n = 0, wr = 0, rd = 0, ce = 1;
  logic [7:0] addr = 0, wdat = 0, req = 0, skip = 0, lvl = 0, v, w8;
  logic [1:0] ack = 0;
  logic [2:0] src = 0;
  wire [7:0] pins, rdata, grant;
  wire i0, i1, pmi, ui, vi, pmp, up, vp;
  int n_errors = 0, num_checks = 0;
  eic_src_model SRC (.sys_clk(sys_clk), .level(lvl), .port0_pin(pins));
  eic_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce), .port0_pin(pins),
    .periph_pin_req(req), .crossbar_skip_mask(skip), .sfr_addr(addr), .sfr_wdata(wdat),
    .sfr_wr(wr), .sfr_rd(rd), .ext_vector_ack(ack), .port_match_req(src[2]),
    .uart1_req(src[1]), .vbus_req(src[0]), .sfr_rdata(rdata), .crossbar_grant(grant),
    .ext_irq_zero(i0), .ext_irq_one(i1), .port_match_irq(pmi), .uart1_irq(ui), .vbus_irq(vi),
    .port_match_priority(pmp), .uart1_priority(up), .vbus_priority(vp));
  initial forever #25 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    wr = w;
    rd = !w;
    addr = a;
    wdat = d;
    cyc(1);
    wr = 0;
    rd = 0;
    v = rdata;
  endtask
  function logic act(input logic [7:0] p, input logic pol, input logic [2:0] s);
    act = p[s] == pol;
  endfunction
  initial begin
    void'($urandom(32'h9f70));
    cyc(12);
    rst_n = 1;
    acc(0, 8'he4, 0);
    chk("cfg_rst", v, 8'h01);
    acc(0, 8'hf7, 0);
    chk("prio_rst", v, 8'h00);
    acc(0, 8'he0, 0);
    chk("unmapped", v, 8'h00);
    repeat (8) begin
      w8 = $urandom & 32'hfb;
      acc(1, 8'hf7, w8);
      chk("prio", {5'h0, pmp, up, vp}, {5'h0, w8[3], w8[1:0]});
      acc(0, 8'hf7, 0);
      chk("prio_rd", v, w8 & 8'h0f);
      acc(1, 8'he7, w8);
      src = $urandom;
      req = $urandom;
      skip = $urandom;
      #1;
      chk("gate", {5'h0, pmi, ui, vi}, {5'h0, src & {w8[3], w8[1:0]}});
      chk("grant", grant, req & ~skip);
    end
    ce = 0;
    acc(1, 8'hf7, ~w8 & 8'h0b);
    ce = 1;
    chk("freeze", {5'h0, pmp, up, vp}, {5'h0, w8[3], w8[1:0]});
    acc(1, 8'h88, 8'h00);
    for (int k = 0; k < 16; k++) begin
      w8 = {k[3], k[2:0], !k[3], ~k[2:0]};
      acc(1, 8'he4, w8);
      lvl = $urandom;
      cyc(6);
      chk("lvl0", i0, act(lvl, w8[3], w8[2:0]));
      chk("lvl1", i1, act(lvl, w8[7], w8[6:4]));
    end
    lvl = 0;
    acc(1, 8'he4, 8'h88);
    cyc(6);
    acc(1, 8'h88, 8'h05);
    lvl = 8'h01;
    cyc(6);
    chk("edge_set", {i1, i0}, 8'h03);
    lvl = 0;
    cyc(6);
    chk("edge_hold", {i1, i0}, 8'h03);
    ack = 2'b01;
    cyc(1);
    ack = 0;
    chk("ack_clr", {i1, i0}, 8'h02);
    acc(0, 8'h88, 0);
    chk("timer_control_reg", v, 8'h0d);
    acc(1, 8'h88, 8'h0f);
    chk("sw_set", {i1, i0}, 8'h03);
    ack = 2'b10;
    cyc(1);
    ack = 0;
    chk("ack1_clr", {i1, i0}, 8'h01);
    acc(1, 8'h88, 8'h05);
    chk("sw_clr", {i1, i0}, 8'h00);
    give_verdict;
  end
endmodule
